// ==== rtl/jtbyp_tap.sv ====
// tap controller, instruction register and bypass path
`timescale 1ns/1ps
`include "jtbyp_params.svh"
module jtbyp_tap
	import jtbyp_pkg::*;
#(
	parameter int IR_WIDTH = `JTBYP_IR_WIDTH
) (
	// system side
	input  wire logic                clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                compliance_sel_i,
	// test port pins
	input  wire logic                tck_i,
	input  wire logic                tms_i,
	input  wire logic                tdi_i,
	input  wire logic                trst_n_i,
	output logic                     tdo_o,
	output logic                     tdo_oe_n_o,
	// pull-up controls for the shared inputs
	output logic                     pullup_tdi_o,
	output logic                     pullup_tms_o,
	output logic                     pullup_trst_o,
	// debug functions, system clock domain
	output logic                     debug_mode_o,
	output logic                     debug_serial_in_o,
	output logic                     breakpoint_request_o,
	output logic                     debug_serial_clock_o,
	// tap state seen in the system domain
	output logic                     tap_in_reset_o,
	output logic [IR_WIDTH-1:0]      instr_o
);
	// system-domain synchronisers: compliance select and the shared pins
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic [3:0] nxt_meta;
	logic [3:0] nxt_sync;
	// tck-domain copy of compliance select
	logic       tmode_meta_ff;
	logic       tmode_ff;
	logic       nxt_tmode_meta;
	logic       nxt_tmode;
	// tap state
	jtbyp_state_type         state_ff;
	jtbyp_state_type         nxt_state;
	logic [IR_WIDTH-1:0]     ir_sh_ff;
	logic [IR_WIDTH-1:0]     nxt_ir_sh;
	logic [IR_WIDTH-1:0]     ir_ff;
	logic [IR_WIDTH-1:0]     nxt_ir;
	logic                    byp_ff;
	logic                    nxt_byp;
	logic                    tdo_ff;
	logic                    nxt_tdo;
	logic                    tdo_en_ff;
	logic                    nxt_tdo_en;
	logic                    test_rst;
	// tck-domain flag for test logic reset, a single bit that crosses cleanly
	logic                    in_tlr_ff;
	logic                    nxt_in_tlr;
	// system-domain output registers
	logic                    rstq_meta_ff;
	logic                    rstq_ff;
	logic [IR_WIDTH-1:0]     irq_meta_ff;
	logic [IR_WIDTH-1:0]     irq_sync_ff;
	logic [IR_WIDTH-1:0]     irq_hold_ff;
	logic [IR_WIDTH-1:0]     irq_ff;
	logic [IR_WIDTH-1:0]     nxt_irq;
	logic                    dbg_ff;
	logic                    pu_ff;
	logic [2:0]              dbgpin_ff;
	logic                    nxt_dbg;
	logic                    nxt_pu;
	logic [2:0]              nxt_dbgpin;

	// bit 0 compliance, 1 tdi, 2 tms, 3 trst
	always_comb begin
		nxt_meta = {trst_n_i, tms_i, tdi_i, compliance_sel_i};
		nxt_sync = meta_ff;
		nxt_dbg = sync_ff[0];
		nxt_pu = ~sync_ff[0];
		// debug functions only live while compliance select is high
		nxt_dbgpin = sync_ff[0] ? sync_ff[3:1] : 3'h0;
		// instruction word is taken only once two synced samples agree,
		// so a word caught while its bits change never reaches the output
		nxt_irq = (irq_sync_ff == irq_hold_ff) ? irq_hold_ff : irq_ff;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_ff      <= 4'h0;
			sync_ff      <= 4'h0;
			dbg_ff       <= 1'b0;
			pu_ff        <= 1'b0;
			dbgpin_ff    <= 3'h0;
			rstq_meta_ff <= 1'b1;
			rstq_ff      <= 1'b1;
			irq_meta_ff  <= `JTBYP_IR_RESET;
			irq_sync_ff  <= `JTBYP_IR_RESET;
			irq_hold_ff  <= `JTBYP_IR_RESET;
			irq_ff       <= `JTBYP_IR_RESET;
		end else begin
			meta_ff      <= nxt_meta;
			sync_ff      <= nxt_sync;
			dbg_ff       <= nxt_dbg;
			pu_ff        <= nxt_pu;
			dbgpin_ff    <= nxt_dbgpin;
			rstq_meta_ff <= in_tlr_ff;
			rstq_ff      <= rstq_meta_ff;
			irq_meta_ff  <= ir_ff;
			irq_sync_ff  <= irq_meta_ff;
			irq_hold_ff  <= irq_sync_ff;
			irq_ff       <= nxt_irq;
		end
	end

	// forced test reset: pin low or compliance select high
	assign test_rst = ~trst_n_i | compliance_sel_i;

	always_comb begin
		nxt_tmode_meta = compliance_sel_i;
		nxt_tmode = tmode_meta_ff;
	end

	always_ff @(posedge tck_i) begin
		tmode_meta_ff <= nxt_tmode_meta;
		tmode_ff      <= nxt_tmode;
	end

	// sixteen-state controller
	always_comb begin
		case (state_ff)
		JTBYP_RESET:      nxt_state = tms_i ? JTBYP_RESET     : JTBYP_IDLE;
		JTBYP_IDLE:       nxt_state = tms_i ? JTBYP_SEL_DR    : JTBYP_IDLE;
		JTBYP_SEL_DR:     nxt_state = tms_i ? JTBYP_SEL_IR    : JTBYP_CAPTURE_DR;
		JTBYP_CAPTURE_DR: nxt_state = tms_i ? JTBYP_EXIT1_DR  : JTBYP_SHIFT_DR;
		JTBYP_SHIFT_DR:   nxt_state = tms_i ? JTBYP_EXIT1_DR  : JTBYP_SHIFT_DR;
		JTBYP_EXIT1_DR:   nxt_state = tms_i ? JTBYP_UPDATE_DR : JTBYP_PAUSE_DR;
		JTBYP_PAUSE_DR:   nxt_state = tms_i ? JTBYP_EXIT2_DR  : JTBYP_PAUSE_DR;
		JTBYP_EXIT2_DR:   nxt_state = tms_i ? JTBYP_UPDATE_DR : JTBYP_SHIFT_DR;
		JTBYP_UPDATE_DR:  nxt_state = tms_i ? JTBYP_SEL_DR    : JTBYP_IDLE;
		JTBYP_SEL_IR:     nxt_state = tms_i ? JTBYP_RESET     : JTBYP_CAPTURE_IR;
		JTBYP_CAPTURE_IR: nxt_state = tms_i ? JTBYP_EXIT1_IR  : JTBYP_SHIFT_IR;
		JTBYP_SHIFT_IR:   nxt_state = tms_i ? JTBYP_EXIT1_IR  : JTBYP_SHIFT_IR;
		JTBYP_EXIT1_IR:   nxt_state = tms_i ? JTBYP_UPDATE_IR : JTBYP_PAUSE_IR;
		JTBYP_PAUSE_IR:   nxt_state = tms_i ? JTBYP_EXIT2_IR  : JTBYP_PAUSE_IR;
		JTBYP_EXIT2_IR:   nxt_state = tms_i ? JTBYP_UPDATE_IR : JTBYP_SHIFT_IR;
		JTBYP_UPDATE_IR:  nxt_state = tms_i ? JTBYP_SEL_DR    : JTBYP_IDLE;
		default:          nxt_state = JTBYP_RESET;
		endcase
		if (tmode_ff) begin
			nxt_state = JTBYP_RESET;
		end
		nxt_ir_sh = ir_sh_ff;
		nxt_ir = ir_ff;
		nxt_byp = byp_ff;
		case (state_ff)
		JTBYP_CAPTURE_IR: nxt_ir_sh = `JTBYP_IR_CAPTURE;
		JTBYP_SHIFT_IR:   nxt_ir_sh = {tdi_i, ir_sh_ff[IR_WIDTH-1:1]};
		JTBYP_UPDATE_IR:  nxt_ir = ir_sh_ff;
		JTBYP_CAPTURE_DR: nxt_byp = 1'b0;
		JTBYP_SHIFT_DR:   nxt_byp = tdi_i;
		default:          nxt_byp = byp_ff;
		endcase
		// instruction falls back to bypass as the controller enters test logic reset
		if (nxt_state == JTBYP_RESET) begin
			nxt_ir = `JTBYP_IR_RESET;
		end
		nxt_in_tlr = (nxt_state == JTBYP_RESET);
	end

	// state moves on tck rising edges or on a forced test reset, so a stopped clock holds it while test reset is off
	always_ff @(posedge tck_i or posedge test_rst) begin
		if (test_rst) begin
			state_ff <= JTBYP_RESET;
			ir_sh_ff <= `JTBYP_IR_RESET;
			ir_ff    <= `JTBYP_IR_RESET;
			byp_ff   <= 1'b0;
			in_tlr_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			ir_sh_ff <= nxt_ir_sh;
			ir_ff    <= nxt_ir;
			byp_ff   <= nxt_byp;
			in_tlr_ff <= nxt_in_tlr;
		end
	end

	// tdo changes on the falling edge of tck
	always_comb begin
		nxt_tdo_en = (state_ff == JTBYP_SHIFT_DR) | (state_ff == JTBYP_SHIFT_IR);
		if (state_ff == JTBYP_SHIFT_IR) begin
			nxt_tdo = ir_sh_ff[0];
		end else if (ir_ff == `JTBYP_BYPASS_OPCODE) begin
			nxt_tdo = byp_ff;
		end else begin
			nxt_tdo = byp_ff;
		end
	end

	always_ff @(negedge tck_i or posedge test_rst) begin
		if (test_rst) begin
			tdo_ff    <= 1'b0;
			tdo_en_ff <= 1'b0;
		end else begin
			tdo_ff    <= nxt_tdo;
			tdo_en_ff <= nxt_tdo_en;
		end
	end

	assign tdo_o                = tdo_ff;
	assign tdo_oe_n_o           = ~tdo_en_ff;
	assign pullup_tdi_o         = pu_ff;
	assign pullup_tms_o         = pu_ff;
	assign pullup_trst_o        = pu_ff;
	assign debug_mode_o         = dbg_ff;
	assign debug_serial_in_o    = dbgpin_ff[0];
	assign breakpoint_request_o = dbgpin_ff[1];
	assign debug_serial_clock_o = dbgpin_ff[2];
	assign tap_in_reset_o       = rstq_ff;
	assign instr_o              = irq_ff;
endmodule // jtbyp_tap

// ==== rtl/jtbyp_params.svh ====
// constants for the test access port block
`ifndef JTBYP_PARAMS_SVH
`define JTBYP_PARAMS_SVH
`define JTBYP_IR_WIDTH      4
`define JTBYP_IR_RESET      4'hF
`define JTBYP_IR_CAPTURE    4'h1
`define JTBYP_BYPASS_OPCODE 4'hF
`define JTBYP_RESET_TMS_EDGES 5
`endif

// ==== rtl/jtbyp_pkg.sv ====
// types for the test access port block
package jtbyp_pkg;
	typedef enum logic [3:0] {
		JTBYP_RESET      = 4'h0,
		JTBYP_IDLE       = 4'h1,
		JTBYP_SEL_DR     = 4'h3,
		JTBYP_CAPTURE_DR = 4'h2,
		JTBYP_SHIFT_DR   = 4'h6,
		JTBYP_EXIT1_DR   = 4'h7,
		JTBYP_PAUSE_DR   = 4'h5,
		JTBYP_EXIT2_DR   = 4'h4,
		JTBYP_UPDATE_DR  = 4'hC,
		JTBYP_SEL_IR     = 4'hD,
		JTBYP_CAPTURE_IR = 4'hF,
		JTBYP_SHIFT_IR   = 4'hE,
		JTBYP_EXIT1_IR   = 4'hA,
		JTBYP_PAUSE_IR   = 4'hB,
		JTBYP_EXIT2_IR   = 4'h9,
		JTBYP_UPDATE_IR  = 4'h8
	} jtbyp_state_type;
endpackage

// ==== tb/jtbyp_host.sv ====
// tester model driving the test port pins
`timescale 1ns/1ps
module jtbyp_host (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_n_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_n_i
);
	initial {tck_o, tms_o, tdi_o, trst_n_o} = 4'b0111;
	// one test clock period, clock stands low between calls
	task automatic step(input logic m, d, output logic q, oe_n);
		{tms_o, tdi_o} = {m, d};
		#62.5;
		// tdo was launched on the last falling edge; sample it just before the rise
		q = tdo_i;
		oe_n = tdo_oe_n_i;
		tck_o = 1'b1;
		#62.5 tck_o = 1'b0;
	endtask
endmodule // jtbyp_host

// ==== tb/jtbyp_tap_asserts.sv ====
// assertions on the test access port block
`timescale 1ns/1ps
`include "jtbyp_params.svh"
module jtbyp_tap_asserts #(parameter int IR_WIDTH = 4) (
	input wire logic                clk_i, sys_rst_i, compliance_sel_i, tck_i, tms_i, tdi_i, trst_n_i,
	input wire logic                pullup_tdi_o, pullup_tms_o, pullup_trst_o, debug_mode_o, tap_in_reset_o,
	input wire logic                debug_serial_in_o, breakpoint_request_o, debug_serial_clock_o,
	input wire logic [IR_WIDTH-1:0] instr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire logic [2:0] pu = {pullup_tdi_o, pullup_tms_o, pullup_trst_o};
	wire logic [2:0] dbg = {debug_serial_in_o, breakpoint_request_o, debug_serial_clock_o};
	a_pullup_scan: assert property ((!compliance_sel_i)[*4] |=> pu == 3'h7)
		else $error("pull-ups off in scan mode");
	a_pullup_debug: assert property (compliance_sel_i[*4] |=> pu == 3'h0)
		else $error("pull-ups on in debug mode");
	a_debug_sync: assert property ($stable(compliance_sel_i)[*5] |=> debug_mode_o == $past(compliance_sel_i))
		else $error("debug mode not following pin");
	a_debug_pins: assert property ((compliance_sel_i && tms_i && tdi_i && trst_n_i)[*5] |=> dbg == 3'h7)
		else $error("debug pins not routed");
	a_debug_quiet: assert property ((!compliance_sel_i)[*5] |=> dbg == 3'h0)
		else $error("debug pins active in scan mode");
	a_hold_reset: assert property (compliance_sel_i[*5] |=> tap_in_reset_o && instr_o == `JTBYP_IR_RESET)
		else $error("controller not held in reset");
	a_trst_reset: assert property ((!trst_n_i)[*5] |=> tap_in_reset_o && instr_o == `JTBYP_IR_RESET)
		else $error("test reset ignored");
	a_tck_static: assert property (($stable(tck_i) && trst_n_i && !compliance_sel_i)[*6] |=> $stable(instr_o))
		else $error("state lost while clock stopped");
	cover property (compliance_sel_i[*5]);
	cover property ($fell(tap_in_reset_o));
	cover property (instr_o != `JTBYP_IR_RESET);
endmodule // jtbyp_tap_asserts
bind jtbyp_tap jtbyp_tap_asserts #(.IR_WIDTH(IR_WIDTH)) i_chk (.*);

// ==== tb/jtbyp_tap_test.sv ====
// self-checking bench for the test access port block
`timescale 1ns/1ps
`include "jtbyp_params.svh"
module jtbyp_tap_test;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, compliance_sel_i = 1'b0, tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_n_o;
	logic pullup_tdi_o, pullup_tms_o, pullup_trst_o, debug_mode_o, debug_serial_in_o, breakpoint_request_o;
	logic debug_serial_clock_o, tap_in_reset_o, q, oe_n, prev;
	logic [3:0] instr_o, ir;
	logic [31:0] seed = 32'hb72020cc;
	int num_errors = 0, checked = 0;
	jtbyp_host i_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i), .tdo_i(tdo_o),
		.tdo_oe_n_i(tdo_oe_n_o));
	jtbyp_tap i_dut (.*);
	initial forever #2 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic walk(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++) i_host.step(m[i], 1'b0, q, oe_n);
	endtask
	task automatic sys_wait(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	initial begin
		repeat (50000) @(posedge clk_i);
		num_errors++;
		end_of_test();
	end
	initial begin
		sys_wait(10);
		sys_rst_i = 1'b0;
		i_host.trst_n_o = 1'b0;
		sys_wait(8);
		chk({tap_in_reset_o, instr_o}, 5'h1F, "test reset");
		i_host.trst_n_o = 1'b1;
		// a random instruction first, then the bypass opcode as a fixed corner
		for (int r = 0; r < 2; r++) begin
			seed = lfsr(seed);
			ir = r ? `JTBYP_BYPASS_OPCODE : seed[3:0];
			walk(8'h06, 5);
			for (int i = 0; i < 4; i++) begin
				i_host.step(i == 3, ir[i], q, oe_n);
				chk({oe_n, q}, {1'b0, i == 0}, "instruction capture");
			end
			walk(8'h01, 5);
			sys_wait(8);
			chk({tap_in_reset_o, instr_o}, {1'b0, ir}, "instruction load");
		end
		// idle to shift-dr through select and capture
		walk(8'h01, 3);
		prev = 1'b0;
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			if (seed[5]) #300;
			i_host.step(1'b0, seed[0], q, oe_n);
			chk({oe_n, q}, {1'b0, prev}, "bypass bit");
			prev = seed[0];
		end
		walk(8'h0F, 4);
		sys_wait(8);
		chk(tap_in_reset_o, 1'b0, "early reset");
		walk(8'h01, 1);
		sys_wait(8);
		chk({tap_in_reset_o, instr_o}, 5'h1F, "five edge reset");
		walk(8'h00, 1);
		sys_wait(8);
		compliance_sel_i = 1'b1;
		walk(8'h00, 3);
		for (int k = 0; k < 8; k++) begin
			{i_host.tdi_o, i_host.tms_o, i_host.trst_n_o} = k[2:0];
			sys_wait(8);
			chk({tap_in_reset_o, debug_serial_in_o, breakpoint_request_o, debug_serial_clock_o}, {1'b1, k[2:0]}, "debug");
			chk({debug_mode_o, pullup_tdi_o, pullup_tms_o, pullup_trst_o}, 4'h8, "debug mode");
		end
		compliance_sel_i = 1'b0;
		sys_wait(8);
		chk({tap_in_reset_o, pullup_tdi_o, pullup_tms_o, pullup_trst_o}, 4'hF, "scan mode");
		end_of_test();
	end
endmodule // jtbyp_tap_test
